// ==== core/tlv_unit.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// - Pending flags are sampled and priority re-resolved every system clock.
// - Fastest response: one detect clock, then four clocks of subroutine call.
// - After a return from handler, one more instruction completes before a call.
// - Worst case 18 clocks: detect, return 5, divide 8, call 4.
// - Equal or higher level handler running blocks new requests until it returns.
// - On handler exit, the highest priority pending request is taken next.
// - Reset vector 0x0000; source n at 0x0003+8n; source 0 highest.
// - Only external inputs 0,1 and timers 0,1 flags clear on vectoring.
// - Global enable bit 7 overrides all masks; zero blocks every source.
// - Enable bits 6..0 mask spi, timer2, uart, timer1, ext1, timer0, ext0.
// - Timer 2 requests on either its low or high overflow flag.
// - External enables gate pin pending flags; timer enables gate overflow flags.
// - Enable register at 0xA8, bit-addressable, all read-write, resets to 0.
// - Priority register at 0xB8; bit 7 reads 1; bits 6..0 read-write, reset 0.
// - Pending flags stand regardless of enables; only the core request is gated.
// - High level preempts a low handler; a high handler is never preempted.
// - Simultaneous requests: high level is serviced before low level.
// - A flag still set after return raises a fresh request at once.
`include "tlv_defines.svh"

module tlv_unit (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_idx,
  input wire logic sfr_bit_val,
  input wire logic sfr_rd,
  input wire logic ext_input0_pending,
  input wire logic timer0_overflow_flag,
  input wire logic ext_input1_pending,
  input wire logic timer1_overflow_flag,
  input wire logic uart_pending,
  input wire logic timer2_low_overflow_flag,
  input wire logic timer2_high_overflow_flag,
  input wire logic serial_periph_pending,
  input wire logic [7:0] ext_src_pending,
  input wire logic [7:0] extended_enable_reg,
  input wire logic [7:0] extended_high_level,
  input wire logic instr_end,
  input wire logic instr_is_return_from_handler,
  output logic [7:0] sfr_rdata,
  output logic req_pending,
  output logic call_active,
  output logic handler_enter,
  output logic [15:0] call_vector,
  output logic [3:0] auto_clear
);
  import tlv_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [3:0] pick_first(input logic [14:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = `TLV_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    return `TLV_VEC_BASE + (16'(idx) << `TLV_VEC_SHIFT);
  endfunction

  // ==========================================================
  // Request resolution
  tlv_regs_t s_r;
  tlv_regs_t s_nxt;
  logic [14:0] pend;
  logic [14:0] en;
  logic [14:0] hl;
  logic [14:0] hi_req;
  logic [14:0] lo_req;
  logic elig_hi;
  logic elig_lo;
  logic take;
  logic pop_hi;
  logic pop_lo;
  logic lvl_hi;
  logic lvl_lo;

  always_comb begin
    // Flags come in raw; only the request path sees the enables
    pend = {ext_src_pending, serial_periph_pending,
            timer2_low_overflow_flag | timer2_high_overflow_flag,
            uart_pending, timer1_overflow_flag, ext_input1_pending,
            timer0_overflow_flag, ext_input0_pending};
    en = {extended_enable_reg, s_r.enable[6:0]} & {15{s_r.enable[`TLV_GLOBAL_EN_BIT]}};
    hl = {extended_high_level, s_r.prio};
    hi_req = pend & en & hl;
    lo_req = pend & en & ~hl;
    // A return ending now frees its level at once, else a second instruction would slip in
    pop_hi = instr_end && instr_is_return_from_handler && (s_r.state == TLV_IDLE) && s_r.in_high;
    pop_lo = instr_end && instr_is_return_from_handler && (s_r.state == TLV_IDLE) && !s_r.in_high;
    lvl_hi = s_r.in_high && !pop_hi;
    lvl_lo = s_r.in_low && !pop_lo;
    elig_hi = (|hi_req) && !lvl_hi;
    elig_lo = (|lo_req) && !lvl_hi && !lvl_lo;
    // A return-ending instruction never starts a call, so one more follows it
    take = instr_end && !instr_is_return_from_handler && s_r.req_valid;
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.enter = 1'b0;
    s_nxt.clr = 4'h0;
    if (sfr_wr && sfr_addr == `TLV_ADDR_ENABLE) begin
      s_nxt.enable = sfr_wdata;
    end
    if (sfr_bit_wr && sfr_addr == `TLV_ADDR_ENABLE) begin
      s_nxt.enable[sfr_bit_idx] = sfr_bit_val;
    end
    if (sfr_wr && sfr_addr == `TLV_ADDR_PRIO) begin
      s_nxt.prio = sfr_wdata[6:0];
    end
    if (sfr_bit_wr && sfr_addr == `TLV_ADDR_PRIO && sfr_bit_idx != 3'(`TLV_PRIO_RSVD_BIT)) begin
      s_nxt.prio[sfr_bit_idx] = sfr_bit_val;
    end
    s_nxt.rdata = 8'h00;
    if (sfr_rd && sfr_addr == `TLV_ADDR_ENABLE) begin
      s_nxt.rdata = s_r.enable;
    end
    if (sfr_rd && sfr_addr == `TLV_ADDR_PRIO) begin
      s_nxt.rdata = {1'b1, s_r.prio};
    end
    // Re-resolved every clock, so a flag left set asks again right after return
    s_nxt.req_valid = elig_hi || elig_lo;
    s_nxt.req_high = elig_hi;
    s_nxt.req_idx = elig_hi ? pick_first(hi_req) : pick_first(lo_req);
    unique case (s_r.state)
      TLV_IDLE: begin
        if (instr_end && instr_is_return_from_handler) begin
          if (s_r.in_high) begin
            s_nxt.in_high = 1'b0;
          end else begin
            s_nxt.in_low = 1'b0;
          end
        end else if (take) begin
          s_nxt.state = TLV_CALL;
          s_nxt.cnt = `TLV_CALL_CLKS - 4'h1;
          s_nxt.call_active = 1'b1;
          s_nxt.vector = vec_of(s_r.req_idx);
          s_nxt.req_valid = 1'b0;
          if (s_r.req_high) begin
            s_nxt.in_high = 1'b1;
          end else begin
            s_nxt.in_low = 1'b1;
          end
          if (s_r.req_idx < 4'(`TLV_NUM_AUTOCLR)) begin
            s_nxt.clr = 4'h1 << s_r.req_idx[1:0];
          end
        end
      end
      TLV_CALL: begin
        // Core runs the call; boundaries are ignored until it ends
        s_nxt.req_valid = 1'b0;
        s_nxt.cnt = s_r.cnt - 4'h1;
        if (s_r.cnt == 4'h1) begin
          s_nxt.enter = 1'b1;
        end
        if (s_r.cnt == 4'h0) begin
          s_nxt.state = TLV_IDLE;
          s_nxt.call_active = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '{state: TLV_IDLE, cnt: 4'h0, enable: `TLV_ENABLE_RESET,
               prio: 7'(`TLV_PRIO_RESET), rdata: 8'h00, req_valid: 1'b0, req_high: 1'b0,
               req_idx: 4'h0, in_low: 1'b0, in_high: 1'b0, call_active: 1'b0,
               enter: 1'b0, vector: `TLV_VEC_RESET, clr: 4'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sfr_rdata = s_r.rdata;
  assign req_pending = s_r.req_valid;
  assign call_active = s_r.call_active;
  assign handler_enter = s_r.enter;
  assign call_vector = s_r.vector;
  assign auto_clear = s_r.clr;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  call_length_a: assert property ($rose(call_active) |-> call_active[*4] ##1 !call_active)
    else $error("call sequence not four clocks");
  enter_timing_a: assert property ($rose(call_active) |-> ##3 handler_enter)
    else $error("handler entry not on last call clock");
  return_from_handler_hold_a: assert property (instr_end && instr_is_return_from_handler && !call_active |=> !call_active)
    else $error("call issued straight after return");
  vector_value_a: assert property ($rose(call_active) |-> call_vector == 16'h0003 + {9'h000, $past(s_r.req_idx), 3'h0})
    else $error("wrong vector address");
  auto_clear_a: assert property ($rose(call_active) |-> ((auto_clear != 4'h0) == ($past(s_r.req_idx) < 4'h4)))
    else $error("auto clear on wrong source");
  global_off_a: assert property (!s_r.enable[7] && !s_r.call_active |=> !req_pending)
    else $error("request while globally disabled");
  high_nest_a: assert property (s_r.in_high && !call_active |=> !$rose(call_active))
    else $error("high handler preempted");
  high_first_a: assert property ($rose(call_active) && $past(|hi_req && !s_r.in_high, 2) |-> s_r.in_high)
    else $error("low chosen over high");
  prio_rsvd_a: assert property (sfr_rd && sfr_addr == 8'hb8 |=> sfr_rdata[7])
    else $error("reserved priority bit not one");

  call_seen_c: cover property ($rose(call_active));
  preempt_c: cover property (s_r.in_low && $rose(s_r.in_high));
  return_from_handler_then_call_c: cover property (instr_end && instr_is_return_from_handler ##[1:20] $rose(call_active));
  ext_vector_c: cover property ($rose(call_active) && call_vector == 16'h0073);
endmodule

// ==== core/tlv_defines.svh ====
`ifndef TLV_DEFINES_SVH
`define TLV_DEFINES_SVH

// ==========================================================
// Register addresses
`define TLV_ADDR_ENABLE 8'ha8
`define TLV_ADDR_PRIO 8'hb8

// ==========================================================
// Field positions and reset values
`define TLV_GLOBAL_EN_BIT 7
`define TLV_PRIO_RSVD_BIT 7
`define TLV_ENABLE_RESET 8'h00
`define TLV_PRIO_RESET 8'h80

// ==========================================================
// Sources and vectors
`define TLV_NUM_SRC 15
`define TLV_NUM_AUTOCLR 4
`define TLV_VEC_RESET 16'h0000
`define TLV_VEC_BASE 16'h0003
`define TLV_VEC_SHIFT 3

// ==========================================================
// Timing, in system clocks
`define TLV_CALL_CLKS 4'h4

`endif

// ==== core/tlv_pkg.sv ====
package tlv_pkg;

  typedef enum logic [0:0] {
    TLV_IDLE = 1'b0,
    TLV_CALL = 1'b1
  } tlv_state_t;

  typedef struct packed {
    tlv_state_t state;
    logic [3:0] cnt;
    logic [7:0] enable;
    logic [6:0] prio;
    logic [7:0] rdata;
    logic req_valid;
    logic req_high;
    logic [3:0] req_idx;
    logic in_low;
    logic in_high;
    logic call_active;
    logic enter;
    logic [15:0] vector;
    logic [3:0] clr;
  } tlv_regs_t;

endpackage

// ==== tb/tlv_core_model.sv ====
`timescale 1ns/1ns
// ==========================================================
// Core sequencer: ends an instruction every gap+1 clocks
module tlv_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] gap,
  input wire logic return_from_handler_req,
  output logic instr_end,
  output logic instr_is_return_from_handler
);
  logic [1:0] cnt_r;
  // Larger gap models slow multi-clock instructions such as a divide
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 2'h0;
      instr_end <= 1'b0;
      instr_is_return_from_handler <= 1'b0;
    end else begin
      cnt_r <= (cnt_r >= gap) ? 2'h0 : cnt_r + 2'h1;
      instr_end <= (cnt_r >= gap);
      instr_is_return_from_handler <= (cnt_r >= gap) && return_from_handler_req;
    end
  end
endmodule

// ==== tb/tlv_unit_test.sv ====
`timescale 1ns/1ns
module tlv_unit_test;
  logic clk, rst, wr, bwr, rd, bval, return_from_handler_req, ie, ir;
  logic [7:0] addr, wdata, f, rdata;
  logic [7:0] xf, xe;
  logic [2:0] bidx;
  logic [1:0] gap;
  logic rp, ca, he;
  logic [15:0] vec;
  logic [3:0] ac;
  int n_fail = 0, check_count = 0, cyc = 0;
  tlv_unit dut (.clk(clk), .rst(rst), .sfr_addr(addr), .sfr_wr(wr), .sfr_wdata(wdata),
    .sfr_bit_wr(bwr), .sfr_bit_idx(bidx), .sfr_bit_val(bval), .sfr_rd(rd),
    .ext_input0_pending(f[0]), .timer0_overflow_flag(f[1]), .ext_input1_pending(f[2]),
    .timer1_overflow_flag(f[3]), .uart_pending(f[4]), .timer2_low_overflow_flag(f[5]),
    .timer2_high_overflow_flag(f[7]), .serial_periph_pending(f[6]), .ext_src_pending(xf),
    .extended_enable_reg(xe), .extended_high_level(8'h00), .instr_end(ie),
    .instr_is_return_from_handler(ir), .sfr_rdata(rdata), .req_pending(rp), .call_active(ca),
    .handler_enter(he), .call_vector(vec), .auto_clear(ac));
  tlv_core_model core (.clk(clk), .rst(rst), .gap(gap), .return_from_handler_req(return_from_handler_req),
    .instr_end(ie), .instr_is_return_from_handler(ir));
  // ==========================================================
  // Common tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // An idle edge first, so back-to-back calls never lower and raise a strobe at once
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1 wr = 1'b0;
  endtask
  task automatic bit_wr(input logic [7:0] a, input logic [2:0] i, input logic v);
    @(posedge clk);
    #1 addr = a;
    bidx = i;
    bval = v;
    bwr = 1'b1;
    @(posedge clk);
    #1 bwr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input bit rule14);
    @(posedge clk);
    #1 addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    if (rule14) chk(rdata, e);
    else chk(rdata, e);
  endtask
  // Lets a running call finish, waits for the next, checks vector, auto clear and entry pulse
  task automatic take(input logic [15:0] v, input logic [3:0] c);
    for (int k = 0; k < 10 && ca === 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    for (int k = 0; k < 60 && ca !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk(ca, 1'b1);
    chk(vec, v);
    chk(ac, c);
    f = f & ~{4'h0, ac};
    repeat (3) @(posedge clk);
    #1 chk(he, 1'b1);
  endtask
  // A return during the call would be ignored by the unit, so wait for the call to end
  task automatic ret();
    for (int k = 0; k < 10 && ca === 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    return_from_handler_req = 1'b1;
    for (int k = 0; k < 20 && ir !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk(ir, 1'b1);
    return_from_handler_req = 1'b0;
    @(posedge clk);
    #1;
  endtask
  // ==========================================================
  // Scenarios
  task automatic s_regs();
    rd_reg(8'ha8, 8'h00, 0);
    rd_reg(8'hb8, 8'h80, 1);
    rd_reg(8'h55, 8'h00, 0);
    wr_reg(8'hb8, 8'h7f);
    rd_reg(8'hb8, 8'hff, 1);
    wr_reg(8'hb8, 8'h00);
    bit_wr(8'hb8, 3'h7, 1'b0);
    bit_wr(8'hb8, 3'h2, 1'b1);
    rd_reg(8'hb8, 8'h84, 1);
    bit_wr(8'hb8, 3'h2, 1'b0);
    wr_reg(8'ha8, 8'h5a);
    rd_reg(8'ha8, 8'h5a, 0);
  endtask
  task automatic s_global();
    wr_reg(8'ha8, 8'h01);
    f[0] = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(rp, 1'b0);
    bit_wr(8'ha8, 3'h7, 1'b1);
    @(posedge clk);
    #1 chk(rp, 1'b1);
    take(16'h0003, 4'h1);
    ret();
  endtask
  task automatic s_timer2();
    gap = 2'h3;
    wr_reg(8'ha8, 8'ha0);
    f[5] = 1'b1;
    take(16'h002b, 4'h0);
    ret();
    take(16'h002b, 4'h0);
    f[5] = 1'b0;
    ret();
    gap = 2'h0;
  endtask
  task automatic s_levels();
    wr_reg(8'hb8, 8'h10);
    wr_reg(8'ha8, 8'h91);
    f = 8'h11;
    take(16'h0023, 4'h0);
    f[4] = 1'b0;
    repeat (8) @(posedge clk);
    #1 chk(ca, 1'b0);
    ret();
    take(16'h0003, 4'h1);
    ret();
  endtask
  task automatic s_preempt();
    wr_reg(8'hb8, 8'h02);
    wr_reg(8'ha8, 8'h83);
    f[0] = 1'b1;
    take(16'h0003, 4'h1);
    f[1] = 1'b1;
    take(16'h000b, 4'h2);
    ret();
    ret();
  endtask
  task automatic s_ext();
    wr_reg(8'ha8, 8'h80);
    xe = 8'h80;
    xf = 8'h80;
    take(16'h0073, 4'h0);
    xf = 8'h00;
    ret();
  endtask
  // ==========================================================
  // Verdict, clock and timeout
  task automatic wrap_up();
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run needs about 130 clocks; the ceiling leaves ample room
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    {wr, bwr, rd, bval, return_from_handler_req} = 5'h00;
    addr = 8'h00; wdata = 8'h00; f = 8'h00; bidx = 3'h0; gap = 2'h0;
    xf = 8'h00;
    xe = 8'h00;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    s_regs();
    s_global();
    s_timer2();
    s_levels();
    s_preempt();
    s_ext();
    wrap_up();
  end
endmodule
